// ### ccr_pkg.sv
// constants, types and decode helpers shared by the condition code core
// assumes an 8-bit datapath and a 32-bit AHB-Lite register bus
package ccr_pkg;

  // datapath and register bank sizes
  localparam int DATA_W       = 8;
  localparam int GPR_PER_BANK = 8;
  localparam int RAM_BYTES    = 128;
  localparam int MAX_BANKS    = 16;
  localparam int IDX_W        = 3;

  // byte offsets on the register bus
  localparam logic [7:0] OFF_PSW      = 8'h00;
  localparam logic [7:0] OFF_RESULT   = 8'h04;
  localparam logic [7:0] OFF_GPR_BASE = 8'h20;
  localparam logic [7:0] OFF_GPR_LAST = 8'h3c;

  // field positions inside the program status word
  localparam int PSW_RP_LSB = 8;
  localparam int CC_H       = 7;
  localparam int CC_I       = 6;
  localparam int CC_IL_LSB  = 4;
  localparam int CC_N       = 3;
  localparam int CC_Z       = 2;
  localparam int CC_V       = 1;
  localparam int CC_C       = 0;

  // reset values
  localparam logic [15:0] PSW_RST = 16'h0000;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // arithmetic and shift operations
  typedef enum logic [2:0] {
    OP_ADD  = 3'h0,
    OP_ADC  = 3'h1,
    OP_SUB  = 3'h2,
    OP_SBC  = 3'h3,
    OP_SHL  = 3'h4,
    OP_SHR  = 3'h5,
    OP_PASS = 3'h6
  } op_t;

  // bus sequencer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'h0,
    BUS_DATA = 2'h1
  } bus_state_t;

  // priority level of a two-bit level code: 00 and 01 are level 1 (highest)
  function automatic logic [1:0] level_of(input logic [1:0] code);
    case (code)
      2'h0:    level_of = 2'h1;
      2'h1:    level_of = 2'h1;
      2'h2:    level_of = 2'h2;
      default: level_of = 2'h3;
    endcase
  endfunction : level_of

  // offset falls inside the general-purpose register window
  function automatic logic is_gpr(input logic [7:0] off);
    is_gpr = (off >= OFF_GPR_BASE) && (off <= OFF_GPR_LAST) && (off[1:0] == 2'h0);
  endfunction : is_gpr

endpackage : ccr_pkg

// ### cc_flag_unit.sv
// combinational arithmetic and shift unit producing result and flags
// assumes the caller registers the outputs and supplies the current H and C
`timescale 1ns/1ps
`default_nettype none
module cc_flag_unit
  import ccr_pkg::*;
(
  // operation and operands
  input  wire op_t              op,
  input  wire logic [DATA_W-1:0] a,
  input  wire logic [DATA_W-1:0] b,
  input  wire logic             c_in,
  input  wire logic             h_in,
  // result and new flags
  output logic [DATA_W-1:0]     res,
  output logic                  h,
  output logic                  n,
  output logic                  z,
  output logic                  v,
  output logic                  c
);

  logic [DATA_W:0] wide;
  logic [4:0]      half;
  logic            cy;

  // operation select with carry or borrow out of bit 7 and from bit 3 to bit 4
  always_comb begin
    wide = '0;
    half = '0;
    cy   = ((op == OP_ADC) || (op == OP_SBC)) ? c_in : 1'b0;
    res  = a;
    h    = h_in;
    v    = 1'b0;
    c    = c_in;
    case (op)
      OP_ADD, OP_ADC: begin
        wide = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cy};
        half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy};
        res  = wide[DATA_W-1:0];
        h    = half[4];
        c    = wide[DATA_W];
        v    = (a[7] == b[7]) && (res[7] != a[7]);
      end
      OP_SUB, OP_SBC: begin
        wide = {1'b0, a} - {1'b0, b} - {{DATA_W{1'b0}}, cy};
        half = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy};
        res  = wide[DATA_W-1:0];
        h    = half[4];
        c    = wide[DATA_W];
        v    = (a[7] != b[7]) && (res[7] != a[7]);
      end
      OP_SHL: begin
        res = {a[DATA_W-2:0], c_in};
        c   = a[DATA_W-1];
      end
      OP_SHR: begin
        res = {c_in, a[DATA_W-1:1]};
        c   = a[0];
      end
      default: begin
        res = a;
      end
    endcase
    n = res[DATA_W-1];
    z = (res == '0);
  end

endmodule : cc_flag_unit
`default_nettype wire

// ### gpr_bank_ram.sv
// memory-resident general-purpose registers, banks of eight bytes
// assumes one write port and one asynchronous read port on the same clock
`timescale 1ns/1ps
`default_nettype none
module gpr_bank_ram
  import ccr_pkg::*;
#(
  parameter int DEPTH = RAM_BYTES,
  parameter int AW    = $clog2(RAM_BYTES)
) (
  // clock and enable
  input  wire logic              clk,
  input  wire logic              ce,
  // write port
  input  wire logic              we,
  input  wire logic [AW-1:0]     waddr,
  input  wire logic [DATA_W-1:0] wdata,
  // read port
  input  wire logic [AW-1:0]     raddr,
  output logic [DATA_W-1:0]      rdata
);

  logic [DATA_W-1:0] mem [DEPTH];

  // byte storage, each register is 8 bits wide
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // read path
  assign rdata = mem[raddr];

endmodule : gpr_bank_ram
`default_nettype wire

// ### condition_code_and_register_banks.sv
// condition code, interrupt gating and register bank core of an 8-bit cpu
// assumes a single AHB-Lite master and cpu execute logic on CLK_SYS
`timescale 1ns/1ps
`default_nettype none
module condition_code_and_register_banks
  import ccr_pkg::*;
#(
  parameter int RAM_SIZE = RAM_BYTES
) (
  // clock, reset, enable
  input  wire logic              CLK_SYS,
  input  wire logic              SYS_RST,
  input  wire logic              CE,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic [31:0]            HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // cpu execute port
  input  wire logic              OP_VALID,
  input  wire op_t               OP_CODE,
  input  wire logic [DATA_W-1:0] OP_A,
  input  wire logic [DATA_W-1:0] OP_B,
  input  wire logic              OP_DEST_EN,
  input  wire logic [IDX_W-1:0]  OP_DEST_IDX,
  output logic [DATA_W-1:0]      RESULT,
  output logic                   RESULT_VALID,
  // interrupt request port
  input  wire logic              IRQ_REQ,
  input  wire logic [1:0]        IRQ_LEVEL,
  output logic                   IRQ_TAKEN,
  // status word view
  output logic [15:0]            PSW
);

  localparam int NUM_BANKS = RAM_SIZE / GPR_PER_BANK;
  localparam int BANK_W    = (NUM_BANKS > 1) ? $clog2(NUM_BANKS) : 1;
  localparam int AW        = BANK_W + IDX_W;

  // refuse memory sizes the bank addressing cannot serve
  initial begin
    if ((RAM_SIZE % GPR_PER_BANK) != 0 || NUM_BANKS < 2 || NUM_BANKS > MAX_BANKS ||
        (1 << BANK_W) != NUM_BANKS) begin
      $error("RAM_SIZE must give a power-of-two bank count from 2 to 16");
    end
  end

  // bus state
  bus_state_t  bstate;
  bus_state_t  next_bstate;
  logic [7:0]  a_off;
  logic [7:0]  next_a_off;
  logic        a_write;
  logic        next_a_write;
  logic [31:0] next_hrdata;
  logic        next_hreadyout;

  // status, result and interrupt state
  logic [15:0]       next_psw;
  logic [DATA_W-1:0] next_result;
  logic              next_result_valid;
  logic              next_irq_taken;

  // flag unit outputs
  logic [DATA_W-1:0] alu_res;
  logic              alu_h;
  logic              alu_n;
  logic              alu_z;
  logic              alu_v;
  logic              alu_c;

  // register memory ports
  logic              ram_we;
  logic [AW-1:0]     ram_waddr;
  logic [DATA_W-1:0] ram_wdata;
  logic [AW-1:0]     ram_raddr;
  logic [DATA_W-1:0] ram_rdata;

  // views of the status word, bus decode and write enables
  logic [7:0]       ccr;
  logic [7:0]       rp;
  logic [BANK_W-1:0] bank;
  logic             bus_take;
  logic             bus_wr_now;
  logic             op_wr;
  logic [IDX_W-1:0] bus_idx;

  assign ccr  = PSW[7:0];
  assign rp   = PSW[15:PSW_RP_LSB];
  assign bank = rp[BANK_W-1:0];

  // arithmetic and shift flag computation
  cc_flag_unit u_flags (
    .op   (OP_CODE),
    .a    (OP_A),
    .b    (OP_B),
    .c_in (ccr[CC_C]),
    .h_in (ccr[CC_H]),
    .res  (alu_res),
    .h    (alu_h),
    .n    (alu_n),
    .z    (alu_z),
    .v    (alu_v),
    .c    (alu_c)
  );

  // banked register storage
  gpr_bank_ram #(
    .DEPTH (RAM_SIZE),
    .AW    (AW)
  ) u_ram (
    .clk   (CLK_SYS),
    .ce    (CE),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );

  // bus address phase capture and register index decode
  assign bus_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  assign bus_idx  = a_off[IDX_W+1:2];
  assign op_wr    = OP_VALID && OP_DEST_EN;
  // a bus write waits while the cpu retires an operation, so neither is lost
  assign bus_wr_now = (bstate == BUS_DATA) && a_write && !OP_VALID;

  // register address is bank pointer followed by index in bank
  always_comb begin
    ram_raddr = {bank, bus_idx};
    ram_we    = 1'b0;
    ram_waddr = {bank, OP_DEST_IDX};
    ram_wdata = alu_res;
    if (op_wr) begin
      ram_we = 1'b1;
    end else if (bus_wr_now && is_gpr(a_off)) begin
      ram_we    = 1'b1;
      ram_waddr = {bank, bus_idx};
      ram_wdata = HWDATA[DATA_W-1:0];
    end
  end

  // bus sequencer next values: one wait state, longer while a write waits on OP_VALID, then answer
  always_comb begin
    next_bstate    = bstate;
    next_a_off     = a_off;
    next_a_write   = a_write;
    next_hrdata    = HRDATA;
    next_hreadyout = HREADYOUT;
    case (bstate)
      BUS_IDLE: begin
        next_hreadyout = 1'b1;
        if (bus_take) begin
          next_bstate    = BUS_DATA;
          next_a_off     = HADDR[7:0];
          next_a_write   = HWRITE;
          next_hreadyout = 1'b0;
        end
      end
      BUS_DATA: begin
        if (!a_write || !OP_VALID) begin
          next_bstate    = BUS_IDLE;
          next_hreadyout = 1'b1;
          next_hrdata    = 32'h0000_0000;
          if (!a_write) begin
            if (a_off == OFF_PSW) begin
              next_hrdata = {16'h0000, PSW};
            end else if (a_off == OFF_RESULT) begin
              next_hrdata = {24'h00_0000, RESULT};
            end else if (is_gpr(a_off)) begin
              next_hrdata = {24'h00_0000, ram_rdata};
            end
          end
        end
      end
      default: begin
        next_bstate    = BUS_IDLE;
        next_hreadyout = 1'b1;
      end
    endcase
  end

  // bus sequencer registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      bstate    <= BUS_IDLE;
      a_off     <= 8'h00;
      a_write   <= 1'b0;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= HRESP_OKAY;
    end else if (CE) begin
      bstate    <= next_bstate;
      a_off     <= next_a_off;
      a_write   <= next_a_write;
      HRDATA    <= next_hrdata;
      HREADYOUT <= next_hreadyout;
      HRESP     <= HRESP_OKAY;
    end
  end

  // status word next value: flags from operations, whole word from the bus
  always_comb begin
    next_psw          = PSW;
    next_result       = RESULT;
    next_result_valid = 1'b0;
    if (OP_VALID) begin
      next_result       = alu_res;
      next_result_valid = 1'b1;
      next_psw[CC_H]    = alu_h;
      next_psw[CC_N]    = alu_n;
      next_psw[CC_Z]    = alu_z;
      next_psw[CC_V]    = alu_v;
      next_psw[CC_C]    = alu_c;
    end else if (bus_wr_now && (a_off == OFF_PSW)) begin
      next_psw = HWDATA[15:0];
    end
  end

  // acceptance: enable set and request level above the mask level
  always_comb begin
    next_irq_taken = IRQ_REQ && ccr[CC_I] &&
                     (level_of(IRQ_LEVEL) <
                      level_of(ccr[CC_IL_LSB+1:CC_IL_LSB]));
  end

  // status, result and interrupt registers
  always_ff @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      PSW          <= PSW_RST;
      RESULT       <= '0;
      RESULT_VALID <= 1'b0;
      IRQ_TAKEN    <= 1'b0;
    end else if (CE) begin
      PSW          <= next_psw;
      RESULT       <= next_result;
      RESULT_VALID <= next_result_valid;
      IRQ_TAKEN    <= next_irq_taken;
    end
  end

endmodule : condition_code_and_register_banks
`default_nettype wire

// ### ccr_checker_sva.sv
// checker for flag, reset and interrupt gating behaviour at the core ports
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module ccr_checker
  import ccr_pkg::*;
#(
  parameter int RAM_SIZE = RAM_BYTES
) (
  // clock, reset, enable
  input wire logic              CLK_SYS,
  input wire logic              SYS_RST,
  input wire logic              CE,
  // execute and interrupt ports
  input wire logic              OP_VALID,
  input wire op_t               OP_CODE,
  input wire logic [DATA_W-1:0] OP_A,
  input wire logic [DATA_W-1:0] OP_B,
  input wire logic              IRQ_REQ,
  input wire logic [1:0]        IRQ_LEVEL,
  input wire logic              IRQ_TAKEN,
  input wire logic [DATA_W-1:0] RESULT,
  input wire logic              RESULT_VALID,
  input wire logic [15:0]       PSW
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  logic [8:0] sum;
  logic       h_add;
  logic       v_add;
  logic       is_add;
  logic       qual;
  // expected add terms and a qualifying request (codes 00 and 01 are both level 1)
  assign sum    = {1'b0, OP_A} + {1'b0, OP_B};
  assign h_add  = ({1'b0, OP_A[3:0]} + {1'b0, OP_B[3:0]}) > 5'h0f;
  assign v_add  = (OP_A[7] == OP_B[7]) && (sum[7] != OP_A[7]);
  assign is_add = CE && OP_VALID && (OP_CODE == OP_ADD);
  assign qual   = IRQ_REQ && PSW[CC_I] && ((IRQ_LEVEL[1] ? IRQ_LEVEL : 2'h1) <
                  (PSW[CC_IL_LSB+1] ? PSW[CC_IL_LSB+:2] : 2'h1));

  a_irq_accept: assert property (CE && qual |=> IRQ_TAKEN)
    else $error("qualifying request not taken");
  a_irq_block: assert property (CE && !qual |=> !IRQ_TAKEN)
    else $error("request taken while gated off");
  a_reset_clear: assert property (disable iff (1'b0) CE && SYS_RST |=> PSW == PSW_RST)
    else $error("status word not cleared by reset");
  a_add_carry: assert property (is_add |=> {PSW[CC_C], RESULT} == $past(sum))
    else $error("add result or carry wrong");
  a_add_half: assert property (is_add |=> PSW[CC_H] == $past(h_add))
    else $error("half carry wrong");
  a_add_ovf: assert property (is_add |=> PSW[CC_V] == $past(v_add))
    else $error("overflow flag wrong");
  a_zero_flag: assert property (CE && OP_VALID |=> PSW[CC_Z] == (RESULT == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (CE && OP_VALID |=> PSW[CC_N] == RESULT[7])
    else $error("negative flag wrong");
  a_shl_carry: assert property (CE && OP_VALID && OP_CODE == OP_SHL |=>
    PSW[CC_C] == $past(OP_A[7])) else $error("shift out not in carry");
  a_valid_pulse: assert property (CE |=> RESULT_VALID == $past(OP_VALID))
    else $error("result valid does not follow the operation");
  a_ce_freeze: assert property (!CE |=> $stable(PSW) && $stable(RESULT))
    else $error("state changed while the clock enable was low");
endmodule : ccr_checker
`default_nettype wire

// ### cpu_model.sv
// cpu execute and interrupt request side facing the core
// assumes its tasks are called just after a rising edge of clk
`timescale 1ns/1ps
`default_nettype none
module cpu_model
  import ccr_pkg::*;
(
  // clock
  input wire logic   clk,
  // execute port
  output logic       op_valid,
  output op_t        op_code,
  output logic [7:0] op_a,
  output logic [7:0] op_b,
  output logic       op_dest_en,
  output logic [2:0] op_dest_idx,
  // interrupt request
  output logic       irq_req,
  output logic [1:0] irq_level
);
  // quiet port at time zero
  initial begin
    {op_valid, op_a, op_b, op_dest_en, op_dest_idx, irq_req, irq_level} = '0;
    op_code = OP_PASS;
  end
  // one operation for exactly one cycle, operands scrambled afterwards
  task automatic exec(input op_t op, input logic [7:0] a, input logic [7:0] b,
                      input logic [2:0] idx);
    op_valid <= 1'b1;
    op_code <= op;
    op_a <= a;
    op_b <= b;
    op_dest_en <= 1'b1;
    op_dest_idx <= idx;
    @(posedge clk);
    op_valid <= 1'b0;
    op_dest_en <= 1'b0;
    op_a <= ~a;
    op_b <= ~b;
  endtask : exec
  // level request held until changed
  task automatic request(input logic r, input logic [1:0] l);
    irq_req <= r;
    irq_level <= l;
  endtask : request
endmodule : cpu_model
`default_nettype wire

// ### condition_code_and_register_banks_bench.sv
// bench for the condition code core: bus, execute and interrupt scenarios
// assumes the checker and the cpu model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module condition_code_and_register_banks_bench
  import ccr_pkg::*;
();
  logic        clk, rst, ce, hw, rdy, resp, rv, ov, de, iq, taken;
  logic [1:0]  ht, il;
  logic [31:0] ha, wd, hrd, d;
  logic [7:0]  res, oa, ob;
  logic [15:0] psw, e;
  logic [2:0]  di;
  op_t         oc;
  int          err_total, checked;
  op_t         ops[8] = '{OP_ADD, OP_ADD, OP_ADD, OP_SUB, OP_SBC, OP_ADC, OP_SHL, OP_SHR};
  logic [7:0]  as[8] = '{8'h0f, 8'h7f, 8'hff, 8'h00, 8'h80, 8'h88, 8'h81, 8'h01};
  logic [7:0]  bs[8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h77, 8'h00, 8'h00};

  condition_code_and_register_banks dut (
    .CLK_SYS(clk), .SYS_RST(rst), .CE(ce), .HSEL(1'b1), .HADDR(ha), .HTRANS(ht),
    .HWRITE(hw), .HSIZE(3'h2), .HWDATA(wd), .HREADY(rdy), .HRDATA(hrd), .HREADYOUT(rdy),
    .HRESP(resp), .OP_VALID(ov), .OP_CODE(oc), .OP_A(oa), .OP_B(ob), .OP_DEST_EN(de),
    .OP_DEST_IDX(di), .RESULT(res), .RESULT_VALID(rv), .IRQ_REQ(iq), .IRQ_LEVEL(il),
    .IRQ_TAKEN(taken), .PSW(psw));
  cpu_model cpu (.clk(clk), .op_valid(ov), .op_code(oc), .op_a(oa), .op_b(ob),
    .op_dest_en(de), .op_dest_idx(di), .irq_req(iq), .irq_level(il));

  // one whole-word transfer: address phase, then data phase until ready
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    ha <= {24'h0, a};
    ht <= HTRANS_NONSEQ;
    hw <= w;
    do @(posedge clk); while (rdy !== 1'b1);
    ht <= 2'h0;
    wd <= v;
    do @(posedge clk); while (rdy !== 1'b1);
    d = hrd;
  endtask : bus
  // priority level of a code, 1 highest
  function automatic logic [1:0] lv(input logic [1:0] c);
    return c[1] ? c : 2'h1;
  endfunction : lv
  // reference result and condition code, I and mask zero, old H zero
  function automatic logic [15:0] model(op_t op, logic [7:0] a, logic [7:0] b, logic ci);
    logic [8:0] s;
    logic       h, v, c, cu;
    cu = (op == OP_ADC || op == OP_SBC) ? ci : 1'b0;
    h = 1'b0;
    v = 1'b0;
    case (op)
      OP_ADD, OP_ADC: begin
        s = a + b + cu;
        h = (a[3:0] + b[3:0] + cu) > 15;
        v = (a[7] == b[7]) && (s[7] != a[7]);
        c = s[8];
      end
      OP_SUB, OP_SBC: begin
        s = a - b - cu;
        h = a[3:0] < (b[3:0] + cu);
        v = (a[7] != b[7]) && (s[7] != a[7]);
        c = a < ({1'b0, b} + cu);
      end
      OP_SHL: begin
        s = {a[6:0], ci};
        c = a[7];
      end
      default: begin
        s = {ci, a[7:1]};
        c = a[0];
      end
    endcase
    return {s[7:0], h, 3'h0, s[7], s[7:0] == 8'h00, v, c};
  endfunction : model
  // counts and verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard
  initial begin
    #100000;
    err_total++;
    summarize();
  end
  // main sequence
  initial begin
    {rst, ce, hw, ht, ha, wd} = {2'b11, 67'h0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    bus(0, OFF_PSW, 0); `CHK(d, 32'h0)
    // every enable, mask code and request level
    for (int i = 0; i < 32; i++) begin
      bus(1, OFF_PSW, {24'h0, 1'b0, i[4], i[3:2], 4'h0});
      cpu.request(1'b1, i[1:0]);
      repeat (2) @(posedge clk);
      `CHK(taken, i[4] && lv(i[1:0]) < lv(i[3:2]))
      cpu.request(1'b0, 2'h0);
    end
    // arithmetic and shift table, result also written to bank 0
    for (int k = 0; k < 8; k++) begin
      bus(1, OFF_PSW, {31'h0, k[0]});
      cpu.exec(ops[k], as[k], bs[k], k[2:0]);
      e = model(ops[k], as[k], bs[k], k[0]);
      bus(0, OFF_RESULT, 0); `CHK(d, {24'h0, e[15:8]})
      bus(0, OFF_PSW, 0); `CHK(d, {24'h0, e[7:0]})
      bus(0, OFF_GPR_BASE + 8'(4 * k), 0); `CHK(d, {24'h0, e[15:8]})
    end
    // banks are separate and only 8 bits wide
    bus(1, OFF_PSW, 32'h0f00);
    bus(1, OFF_GPR_LAST, 32'hffffff5a);
    bus(1, OFF_PSW, 32'h0000);
    bus(1, OFF_GPR_LAST, 32'h000000a5);
    bus(1, OFF_PSW, 32'h0f00);
    bus(0, OFF_GPR_LAST, 0); `CHK(d, 32'h5a)
    bus(0, OFF_PSW, 0); `CHK(d, 32'h0f00)
    bus(1, OFF_PSW, 32'h0000);
    bus(0, OFF_GPR_LAST, 0); `CHK(d, 32'ha5)
    // read-only result and unmapped offset
    bus(1, OFF_RESULT, 32'hff);
    bus(0, OFF_RESULT, 0); `CHK(d, 32'h80)
    bus(0, 8'h10, 0); `CHK(d, 32'h0)
    `CHK(resp, HRESP_OKAY)
    // a held clock enable drops an operation and keeps the old result
    ce <= 1'b0;
    cpu.exec(OP_ADD, 8'h01, 8'h01, 3'h0);
    ce <= 1'b1;
    bus(0, OFF_RESULT, 0); `CHK(d, 32'h80)
    summarize();
  end
endmodule : condition_code_and_register_banks_bench
bind condition_code_and_register_banks ccr_checker #(.RAM_SIZE(RAM_SIZE)) u_chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .CE(CE), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
  .OP_A(OP_A), .OP_B(OP_B), .IRQ_REQ(IRQ_REQ), .IRQ_LEVEL(IRQ_LEVEL),
  .IRQ_TAKEN(IRQ_TAKEN), .RESULT(RESULT), .RESULT_VALID(RESULT_VALID), .PSW(PSW));
`default_nettype wire
